// ---- verilog/pdr_pkg.sv ----
`default_nettype none
package pdr_pkg;

  // ==========================================================
  // register bus
  localparam int          PDR_AW         = 4;
  localparam int          PDR_DW         = 32;
  localparam logic [3:0]  PDR_ADDR_STBY  = 4'h0;
  localparam logic [3:0]  PDR_ADDR_ISO   = 4'h4;
  localparam logic [3:0]  PDR_ADDR_CTRL  = 4'h8;
  localparam logic [3:0]  PDR_ADDR_STAT  = 4'hC;
  localparam logic [31:0] PDR_ZERO       = 32'h0000_0000;

  // ==========================================================
  // power regions
  localparam int          PDR_NREG        = 15;
  localparam logic [31:0] PDR_REGION_MASK = 32'h07FE_02D1;
  localparam logic [31:0] PDR_STBY_RST    = 32'h0000_0000;
  localparam logic [31:0] PDR_ISO_RST     = 32'h0000_0000;
  localparam int          PDR_BIT_ROM     = 17;
  localparam int          PDR_BIT_SRAM_LO = 18;
  localparam int          PDR_BIT_SRAM_HI = 26;
  localparam int          PDR_BIT_AUDIO   = 0;
  localparam int          PDR_BIT_USBRAM  = 4;
  localparam int          PDR_BIT_FCACHE  = 6;
  localparam int          PDR_BIT_SD      = 7;
  localparam int          PDR_BIT_USBPHY  = 9;
  localparam int          PDR_REGION_BIT [0:PDR_NREG-1] = '{
    PDR_BIT_ROM, 18, 19, 20, 21, 22, 23, 24, 25, PDR_BIT_SRAM_HI,
    PDR_BIT_AUDIO, PDR_BIT_USBRAM, PDR_BIT_FCACHE, PDR_BIT_SD, PDR_BIT_USBPHY};

  // ==========================================================
  // control and status fields
  localparam int   PDR_CTRL_MODE   = 0;
  localparam int   PDR_CTRL_OFFCMD = 1;
  localparam logic PDR_MODE_RST    = 1'b1;
  localparam logic PDR_MODE_GEN    = 1'b1;
  localparam logic PDR_MODE_KEY    = 1'b0;
  localparam int   PDR_STAT_ISON   = 0;
  localparam int   PDR_STAT_DOMOFF = 1;
  localparam int   PDR_STAT_MAINOK = 2;
  localparam int   PDR_STAT_CLKOK  = 3;
  localparam int   PDR_STAT_RTCRUN = 4;
  localparam int   PDR_STAT_STATE  = 8;

  // ==========================================================
  // timing
  localparam int PDR_CLK_PERIOD_PS  = 4000;
  localparam int PDR_ISO_SETTLE_NS  = 100;
  localparam int PDR_WAKE_SETTLE_NS = 200;
  localparam int PDR_ISO_CYC  = (PDR_ISO_SETTLE_NS * 1000 + PDR_CLK_PERIOD_PS - 1) / PDR_CLK_PERIOD_PS;
  localparam int PDR_WAKE_CYC = (PDR_WAKE_SETTLE_NS * 1000 + PDR_CLK_PERIOD_PS - 1) / PDR_CLK_PERIOD_PS;
  localparam int PDR_CNT_W    = 8;

  typedef enum logic [3:0] {
    PDR_ON   = 4'b0001,
    PDR_ISOL = 4'b0010,
    PDR_OFF  = 4'b0100,
    PDR_WAKE = 4'b1000
  } pdr_seq_e;

endpackage
`default_nettype wire

// ---- verilog/pdr_seq_if.sv ----
`timescale 1ns/100ps
`default_nettype none
interface pdr_seq_if;
  import pdr_pkg::*;
  logic     mode;
  logic     offCmd;
  logic     extOffTrig;
  logic     wakeKey;
  logic     wakeAlarm;
  logic     mainOk;
  logic     backupIsoN;
  logic     domainOff;
  pdr_seq_e state;

  modport ctrl (output mode, offCmd, extOffTrig, wakeKey, wakeAlarm, mainOk,
                input  backupIsoN, domainOff, state);
  modport seq  (input  mode, offCmd, extOffTrig, wakeKey, wakeAlarm, mainOk,
                output backupIsoN, domainOff, state);
endinterface
`default_nettype wire

// ---- verilog/pdr_backup_seq.sv ----
`timescale 1ns/100ps
`default_nettype none
module pdr_backup_seq
  import pdr_pkg::*;
#(
  parameter int ISO_CYC  = PDR_ISO_CYC,
  parameter int WAKE_CYC = PDR_WAKE_CYC
) (
  input  wire logic clk,
  input  wire logic rstn,
  pdr_seq_if.seq    sif
);
  import pdr_pkg::*;

  typedef struct packed {
    pdr_seq_e              st;
    logic [PDR_CNT_W-1:0]  cnt;
    logic                  isoN;
    logic                  off;
  } pdr_seq_s;

  localparam logic [PDR_CNT_W-1:0] IsoLast  = PDR_CNT_W'(ISO_CYC - 1);
  localparam logic [PDR_CNT_W-1:0] WakeLast = PDR_CNT_W'(WAKE_CYC - 1);

  pdr_seq_s s_q;
  pdr_seq_s s_d;

  // ==========================================================
  // key-wake sequencer
  always_comb begin
    s_d = s_q;
    s_d.cnt = s_q.cnt + PDR_CNT_W'(1);
    if (sif.mode == PDR_MODE_GEN) begin
      s_d.st   = PDR_ON;
      s_d.off  = 1'b0;
      s_d.isoN = sif.mainOk;
    end else begin
      unique case (s_q.st)
        PDR_ON: begin
          s_d.isoN = 1'b1;
          if (sif.offCmd || sif.extOffTrig) begin
            s_d.st   = PDR_ISOL;
            s_d.isoN = 1'b0;
            s_d.cnt  = '0;
          end
        end
        PDR_ISOL: begin
          if (s_q.cnt == IsoLast) begin
            s_d.st  = PDR_OFF;
            s_d.off = 1'b1;
          end
        end
        PDR_OFF: begin
          if (sif.wakeKey || sif.wakeAlarm) begin
            s_d.st  = PDR_WAKE;
            s_d.off = 1'b0;
            s_d.cnt = '0;
          end
        end
        PDR_WAKE: begin
          if (s_q.cnt == WakeLast) begin
            s_d.st   = PDR_ON;
            s_d.isoN = 1'b1;
          end
        end
        default: begin
          s_d.st   = PDR_ON;
          s_d.isoN = 1'b1;
          s_d.off  = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      s_q <= '{st: PDR_ON, cnt: '0, isoN: 1'b1, off: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign sif.backupIsoN = s_q.isoN;
  assign sif.domainOff  = s_q.off;
  assign sif.state      = s_q.st;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  // cycles spent isolating, counted apart from the sequencer counter
  logic [PDR_CNT_W-1:0] isoAge;

  always_ff @(posedge clk) begin
    if (!rstn || (s_q.st != PDR_ISOL)) begin
      isoAge <= '0;
    end else begin
      isoAge <= isoAge + PDR_CNT_W'(1);
    end
  end

  chk_cmd_isolate: assert property (
    (sif.mode == PDR_MODE_KEY) && (s_q.st == PDR_ON) && sif.offCmd |=> !sif.backupIsoN && !sif.domainOff)
    else $error("command did not isolate backup domain");
  chk_ext_trigger: assert property (
    (sif.mode == PDR_MODE_KEY) && (s_q.st == PDR_ON) && sif.extOffTrig |=> (s_q.st == PDR_ISOL))
    else $error("external trigger did not start power-off");
  chk_iso_then_off: assert property (
    (s_q.st == PDR_ISOL) && (isoAge == IsoLast) && (sif.mode == PDR_MODE_KEY) |=> sif.domainOff)
    else $error("power-off not reached after isolation settle");
  chk_iso_not_early: assert property (
    (s_q.st == PDR_ISOL) && (isoAge != IsoLast) |=> !sif.domainOff)
    else $error("power-off before isolation settle");
  chk_wake_start: assert property (
    (sif.mode == PDR_MODE_KEY) && (s_q.st == PDR_OFF) && (sif.wakeKey || sif.wakeAlarm)
    |=> !sif.domainOff && !sif.backupIsoN)
    else $error("wake did not start power-on");
  chk_general_follow: assert property (
    (sif.mode == PDR_MODE_GEN) |=> sif.backupIsoN == $past(sif.mainOk))
    else $error("general mode isolation does not follow supply detect");
  cov_off_cycle: cover property ((s_q.st == PDR_OFF) ##[1:200] (s_q.st == PDR_ON));
  cov_alarm_wake: cover property ((s_q.st == PDR_OFF) && sif.wakeAlarm);
endmodule
`default_nettype wire

// ---- verilog/power_domain_rtc_backup_ctrl.sv ----
// Contract
// - fifteen core regions can each be switched off on their own.
// - the ROM region uses bit 17 of the standby and of the isolation register.
// - the nine SRAM regions use bits 18 to 26 in order, same bit in both registers.
// - the audio region uses bit 0 in both registers.
// - the USB SRAM region uses bit 4 and the flash cache region bit 6 in both registers.
// - in general mode a main supply drop drives the backup isolation low.
// - a low clock supply detect stops the real-time clock.
// - in key-wake mode a processor command makes the sequencer isolate and power off.
// - in key-wake mode an external trigger also starts the power-off sequence.
// - in key-wake mode key wake or clock alarm starts the power-on sequence.
//
// Local design decisions: the plain strobed port and the address map.
`timescale 1ns/100ps
`default_nettype none
module power_domain_rtc_backup_ctrl
  import pdr_pkg::*;
#(
  parameter int ISO_CYC  = PDR_ISO_CYC,
  parameter int WAKE_CYC = PDR_WAKE_CYC
) (
  input  wire logic                       clk,
  input  wire logic                       rstn,
  input  wire logic [pdr_pkg::PDR_AW-1:0] regAddr,
  input  wire logic [pdr_pkg::PDR_DW-1:0] regWdata,
  input  wire logic                       regWr,
  input  wire logic                       regRd,
  output logic      [pdr_pkg::PDR_DW-1:0] regRdata,
  input  wire logic                       mainSupplyOk,
  input  wire logic                       clockSupplyOk,
  input  wire logic                       extOffTrigger,
  input  wire logic                       keyWake,
  input  wire logic                       clockAlarmWake,
  output logic      [pdr_pkg::PDR_NREG-1:0] regionOff,
  output logic      [pdr_pkg::PDR_NREG-1:0] regionIsolate,
  output logic      [pdr_pkg::PDR_DW-1:0] domainStandby,
  output logic      [pdr_pkg::PDR_DW-1:0] domainIsolation,
  output logic                            backupIsolateN,
  output logic                            clockDomainOff,
  output logic                            rtcRun
);
  import pdr_pkg::*;

  typedef struct packed {
    logic [PDR_DW-1:0] stby;
    logic [PDR_DW-1:0] iso;
    logic              mode;
    logic              offCmd;
    logic              rtcRun;
    logic [PDR_DW-1:0] rdata;
  } pdr_top_s;

  pdr_top_s  r_q;
  pdr_top_s  r_d;
  pdr_seq_if sif ();

  logic [PDR_DW-1:0] statusWord;
  logic              hitStby;
  logic              hitIso;
  logic              hitCtrl;

  // ==========================================================
  // address decode
  assign hitStby = (regAddr == PDR_ADDR_STBY);
  assign hitIso  = (regAddr == PDR_ADDR_ISO);
  assign hitCtrl = (regAddr == PDR_ADDR_CTRL);

  always_comb begin
    statusWord                                = PDR_ZERO;
    statusWord[PDR_STAT_ISON]                 = sif.backupIsoN;
    statusWord[PDR_STAT_DOMOFF]               = sif.domainOff;
    statusWord[PDR_STAT_MAINOK]               = mainSupplyOk;
    statusWord[PDR_STAT_CLKOK]                = clockSupplyOk;
    statusWord[PDR_STAT_RTCRUN]               = r_q.rtcRun;
    statusWord[PDR_STAT_STATE+:$bits(pdr_seq_e)] = sif.state;
  end

  // ==========================================================
  // register file
  always_comb begin
    r_d        = r_q;
    r_d.offCmd = 1'b0;
    r_d.rtcRun = clockSupplyOk;
    if (regWr) begin
      if (hitStby) begin
        r_d.stby = regWdata & PDR_REGION_MASK;
      end
      if (hitIso) begin
        r_d.iso = regWdata & PDR_REGION_MASK;
      end
      if (hitCtrl) begin
        r_d.mode   = regWdata[PDR_CTRL_MODE];
        r_d.offCmd = regWdata[PDR_CTRL_OFFCMD];
      end
    end
    r_d.rdata = PDR_ZERO;
    if (regRd) begin
      unique case (regAddr)
        PDR_ADDR_STBY: begin
          r_d.rdata = r_q.stby;
        end
        PDR_ADDR_ISO: begin
          r_d.rdata = r_q.iso;
        end
        PDR_ADDR_CTRL: begin
          r_d.rdata = {{(PDR_DW-1){1'b0}}, r_q.mode};
        end
        PDR_ADDR_STAT: begin
          r_d.rdata = statusWord;
        end
        default: begin
          r_d.rdata = PDR_ZERO;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      r_q <= '{stby: PDR_STBY_RST, iso: PDR_ISO_RST, mode: PDR_MODE_RST,
               offCmd: 1'b0, rtcRun: 1'b0, rdata: PDR_ZERO};
    end else begin
      r_q <= r_d;
    end
  end

  // ==========================================================
  // region outputs
  genvar g;
  generate
    for (g = 0; g < PDR_NREG; g++) begin : gRegion
      assign regionOff[g]     = r_q.stby[PDR_REGION_BIT[g]];
      assign regionIsolate[g] = r_q.iso[PDR_REGION_BIT[g]];
    end
  endgenerate

  assign domainStandby   = r_q.stby;
  assign domainIsolation = r_q.iso;
  assign regRdata        = r_q.rdata;
  assign rtcRun          = r_q.rtcRun;

  // ==========================================================
  // backup sequencer
  assign sif.mode       = r_q.mode;
  assign sif.offCmd     = r_q.offCmd;
  assign sif.extOffTrig = extOffTrigger;
  assign sif.wakeKey    = keyWake;
  assign sif.wakeAlarm  = clockAlarmWake;
  assign sif.mainOk     = mainSupplyOk;

  pdr_backup_seq #(
    .ISO_CYC  (ISO_CYC),
    .WAKE_CYC (WAKE_CYC)
  ) uSeq (
    .clk  (clk),
    .rstn (rstn),
    .sif  (sif)
  );

  assign backupIsolateN = sif.backupIsoN;
  assign clockDomainOff = sif.domainOff;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  chk_unmapped_zero: assert property (
    ((r_q.stby | r_q.iso) & ~PDR_REGION_MASK) == PDR_ZERO)
    else $error("unmapped standby or isolation bit set");
  chk_rom_region: assert property (
    regWr && hitStby |=> regionOff[0] == $past(regWdata[PDR_BIT_ROM]))
    else $error("rom region off does not follow bit 17");
  chk_rom_isolate: assert property (
    regWr && hitIso |=> regionIsolate[0] == $past(regWdata[PDR_BIT_ROM]))
    else $error("rom region isolate does not follow bit 17");
  chk_sram_regions: assert property (
    regWr && hitStby |=> regionOff[9:1] == $past(regWdata[PDR_BIT_SRAM_HI:PDR_BIT_SRAM_LO]))
    else $error("sram regions do not follow bits 18 to 26");
  chk_sram_isolate: assert property (
    regWr && hitIso |=> regionIsolate[9:1] == $past(regWdata[PDR_BIT_SRAM_HI:PDR_BIT_SRAM_LO]))
    else $error("sram isolation does not follow bits 18 to 26");
  chk_audio_region: assert property (
    regWr && hitStby |=> regionOff[10] == $past(regWdata[PDR_BIT_AUDIO]))
    else $error("audio region does not follow bit 0");
  chk_usb_flash: assert property (
    regWr && hitIso |=> regionIsolate[12:11] == {$past(regWdata[PDR_BIT_FCACHE]), $past(regWdata[PDR_BIT_USBRAM])})
    else $error("usb sram or flash cache isolation wrong");
  chk_sd_phy: assert property (
    regWr && hitStby |=> regionOff[14:13] == {$past(regWdata[PDR_BIT_USBPHY]), $past(regWdata[PDR_BIT_SD])})
    else $error("sd or usb phy region wrong");
  chk_general_drop: assert property (
    (r_q.mode == PDR_MODE_GEN) && !mainSupplyOk |=> !backupIsolateN)
    else $error("supply drop did not isolate backup domain");
  chk_rtc_stop: assert property (
    !clockSupplyOk |=> !rtcRun)
    else $error("rtc still running after clock supply drop");
  chk_cmd_path: assert property (
    regWr && hitCtrl && regWdata[PDR_CTRL_OFFCMD] && !regWdata[PDR_CTRL_MODE]
    && (sif.state == PDR_ON) |=> ##1 !backupIsolateN)
    else $error("power-off command did not reach sequencer");
  chk_read_once: assert property (
    !$past(regRd) |-> regRdata == PDR_ZERO)
    else $error("read data outside its cycle");

  // ==========================================================
  // register bus checks
  chk_stby_write: assert property (
    regWr && hitStby
    |=> domainStandby == ($past(regWdata) & PDR_REGION_MASK))
    else $error("standby register write lost");
  chk_iso_write: assert property (
    regWr && hitIso
    |=> domainIsolation == ($past(regWdata) & PDR_REGION_MASK))
    else $error("isolation register write lost");
  chk_unmapped_write: assert property (
    regWr && !hitStby && !hitIso && !hitCtrl
    |=> $stable(domainStandby) && $stable(domainIsolation))
    else $error("unmapped write changed a region register");
  chk_stby_read: assert property (
    regRd && hitStby
    |=> regRdata == domainStandby)
    else $error("standby read data wrong");
  chk_iso_read: assert property (
    regRd && hitIso
    |=> regRdata == domainIsolation)
    else $error("isolation read data wrong");
  chk_read_unmapped: assert property (
    regRd && !hitStby && !hitIso && !hitCtrl && (regAddr != PDR_ADDR_STAT)
    |=> regRdata == PDR_ZERO)
    else $error("unmapped read not zero");
  chk_mode_write: assert property (
    regWr && hitCtrl
    |=> r_q.mode == $past(regWdata[PDR_CTRL_MODE]))
    else $error("mode select write lost");
  chk_ctrl_read: assert property (
    regRd && hitCtrl
    |=> (regRdata >> PDR_CTRL_OFFCMD) == PDR_ZERO)
    else $error("command bit does not read as zero");
  chk_offcmd_pulse: assert property (
    r_q.offCmd && !(regWr && hitCtrl && regWdata[PDR_CTRL_OFFCMD])
    |=> !r_q.offCmd)
    else $error("power-off command longer than one cycle");
  chk_status_flags: assert property (
    regRd && (regAddr == PDR_ADDR_STAT)
    |=> regRdata[PDR_STAT_ISON] == $past(backupIsolateN)
        && regRdata[PDR_STAT_DOMOFF] == $past(clockDomainOff))
    else $error("status isolation flags wrong");
  chk_status_supply: assert property (
    regRd && (regAddr == PDR_ADDR_STAT)
    |=> regRdata[PDR_STAT_MAINOK] == $past(mainSupplyOk)
        && regRdata[PDR_STAT_CLKOK] == $past(clockSupplyOk)
        && regRdata[PDR_STAT_RTCRUN] == $past(rtcRun))
    else $error("status supply flags wrong");

  // ==========================================================
  // sequencer and supply checks
  chk_state_onehot: assert property (
    $onehot(sif.state))
    else $error("sequencer state not one-hot");
  chk_rtc_run: assert property (
    clockSupplyOk
    |=> rtcRun)
    else $error("rtc not running with clock supply present");
  chk_general_on: assert property (
    r_q.mode == PDR_MODE_GEN
    |=> !clockDomainOff)
    else $error("backup domain off in general mode");
  chk_general_ok: assert property (
    (r_q.mode == PDR_MODE_GEN) && mainSupplyOk
    |=> backupIsolateN)
    else $error("backup isolated with main supply present");
  chk_gen_cmd_ignored: assert property (
    regWr && hitCtrl && regWdata[PDR_CTRL_MODE]
    |=> ##1 !clockDomainOff)
    else $error("power-off command acted in general mode");
  chk_off_isolated: assert property (
    clockDomainOff
    |-> !backupIsolateN)
    else $error("backup domain off without isolation");
  chk_off_after_iso: assert property (
    $rose(clockDomainOff)
    |-> !$past(backupIsolateN))
    else $error("power-off before isolation");
  chk_off_hold: assert property (
    clockDomainOff && (r_q.mode == PDR_MODE_KEY) && !keyWake && !clockAlarmWake
    |=> clockDomainOff)
    else $error("backup domain woke without a wake source");
  chk_wake_refused: assert property (
    !clockDomainOff && (r_q.mode == PDR_MODE_KEY) && (sif.state != PDR_WAKE)
    |=> sif.state != PDR_WAKE)
    else $error("wake accepted outside the off state");

  // ==========================================================
  // per-region checks
  for (genvar r = 0; r < PDR_NREG; r++) begin : gRegionChk
    chk_region_off: assert property (@(posedge clk) disable iff (!rstn)
      regWr && hitStby
      |=> regionOff[r] == $past(regWdata[PDR_REGION_BIT[r]]))
      else $error("region off does not follow its standby bit");
    chk_region_iso: assert property (@(posedge clk) disable iff (!rstn)
      regWr && hitIso
      |=> regionIsolate[r] == $past(regWdata[PDR_REGION_BIT[r]]))
      else $error("region isolate does not follow its isolation bit");
    chk_region_keep: assert property (@(posedge clk) disable iff (!rstn)
      !(regWr && hitStby)
      |=> $stable(regionOff[r]))
      else $error("region off changed without a standby write");
    chk_isolate_keep: assert property (@(posedge clk) disable iff (!rstn)
      !(regWr && hitIso)
      |=> $stable(regionIsolate[r]))
      else $error("region isolate changed without an isolation write");
  end

  cov_keywake_off: cover property (clockDomainOff ##[1:300] !clockDomainOff);
  cov_general_drop: cover property ((r_q.mode == PDR_MODE_GEN) && $fell(backupIsolateN));
  cov_status_read: cover property (regRd && (regAddr == PDR_ADDR_STAT));
endmodule
`default_nettype wire

// ---- tb/pdr_supply_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// supply detectors seen by the block
module pdr_supply_model (
  input  wire logic clk,
  input  wire logic mainDrop,
  input  wire logic clkDrop,
  output var  logic mainSupplyOk,
  output var  logic clockSupplyOk
);
  initial begin
    mainSupplyOk  = 1'b1;
    clockSupplyOk = 1'b1;
  end

  // detector flags lag the supply by one clock
  always @(posedge clk) begin
    mainSupplyOk  <= ~mainDrop;
    clockSupplyOk <= ~clkDrop;
  end
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb;
  import pdr_pkg::*;
  localparam int ISO  = 2;
  localparam int WAKE = 3;
  logic        clk, rstn, regWr, regRd, keyWake, clockAlarmWake, extOffTrigger;
  logic        mainDrop, clkDrop, mainSupplyOk, clockSupplyOk;
  logic        backupIsolateN, clockDomainOff, rtcRun;
  logic [3:0]  regAddr;
  logic [31:0] regWdata, regRdata, domainStandby, domainIsolation, v;
  logic [14:0] regionOff, regionIsolate;
  int          errors, cmp_count, cyc, i;

  power_domain_rtc_backup_ctrl #(.ISO_CYC(ISO), .WAKE_CYC(WAKE)) power_domain_rtc_backup_ctrl_inst (
    .clk(clk), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .mainSupplyOk(mainSupplyOk),
    .clockSupplyOk(clockSupplyOk), .extOffTrigger(extOffTrigger), .keyWake(keyWake),
    .clockAlarmWake(clockAlarmWake), .regionOff(regionOff), .regionIsolate(regionIsolate),
    .domainStandby(domainStandby), .domainIsolation(domainIsolation),
    .backupIsolateN(backupIsolateN), .clockDomainOff(clockDomainOff), .rtcRun(rtcRun));

  pdr_supply_model pdr_supply_model_inst (
    .clk(clk), .mainDrop(mainDrop), .clkDrop(clkDrop),
    .mainSupplyOk(mainSupplyOk), .clockSupplyOk(clockSupplyOk));

  // ==========================================================
  // checking helpers
  task automatic report_and_stop;
    $display("errors %0d comparisons %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chkb(input logic got, input logic exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask

  function automatic logic [14:0] exp_reg(input logic [31:0] w);
    for (int k = 0; k < PDR_NREG; k++) exp_reg[k] = w[PDR_REGION_BIT[k]];
  endfunction

  function automatic logic pick(input int sel);
    pick = (sel == 0) ? backupIsolateN : (sel == 1) ? clockDomainOff : rtcRun;
  endfunction

  // bounded wait for one output to reach a level
  task automatic wait_out(input int sel, input logic val, input int lim, input string what);
    for (int k = 0; k < lim && pick(sel) !== val; k++) begin
      @(posedge clk);
      #1;
    end
    chkb(pick(sel), val, what);
  endtask

  // ==========================================================
  // register bus master and wake or trigger input pulses
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    regWr    <= 1'b1;
    regAddr  <= a;
    regWdata <= d;
    @(posedge clk);
    regWr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] exp, input string what);
    @(posedge clk);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1;
    chk(regRdata, exp, what);
  endtask

  task automatic pulse(input int sel);
    @(posedge clk);
    if (sel == 0) keyWake <= 1'b1;
    else if (sel == 1) clockAlarmWake <= 1'b1;
    else extOffTrigger <= 1'b1;
    @(posedge clk);
    keyWake        <= 1'b0;
    clockAlarmWake <= 1'b0;
    extOffTrigger  <= 1'b0;
    #1;
  endtask

  // ==========================================================
  // clock and watchdog
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc >= 5000) begin
      errors++;
      report_and_stop;
    end
  end

  // ==========================================================
  // main sequence
  initial begin
    rstn = 1'b0; regWr = 1'b0; regRd = 1'b0; regAddr = 4'h0; regWdata = 32'h0;
    keyWake = 1'b0; clockAlarmWake = 1'b0; extOffTrigger = 1'b0;
    mainDrop = 1'b0; clkDrop = 1'b0; errors = 0; cmp_count = 0; cyc = 0;
    v = $urandom(32'h82C9);
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    rd(PDR_ADDR_STBY, PDR_STBY_RST, "stby rst");
    rd(PDR_ADDR_ISO, PDR_ISO_RST, "iso rst");
    chkb(backupIsolateN, 1'b1, "backup rst");
    // walking ones, then random words
    for (i = 0; i < 48; i++) begin
      v = (i < 32) ? (32'h1 << i) : $urandom();
      wr(PDR_ADDR_ISO, v);
      chk({17'h0, regionIsolate}, {17'h0, exp_reg(v)}, "iso map");
      chk(domainIsolation, v & PDR_REGION_MASK, "iso reg");
      wr(PDR_ADDR_STBY, v);
      chk({17'h0, regionOff}, {17'h0, exp_reg(v)}, "stby map");
      chk(domainStandby, v & PDR_REGION_MASK, "stby reg");
      rd(PDR_ADDR_STBY, v & PDR_REGION_MASK, "stby rd");
    end
    wr(4'h1, 32'hFFFF_FFFF);
    rd(4'h1, 32'h0, "unmapped rd");
    rd(PDR_ADDR_STBY, v & PDR_REGION_MASK, "unmapped wr");
    wr(PDR_ADDR_STBY, 32'h0);
    wr(PDR_ADDR_ISO, 32'h0);
    // general mode supply drops
    @(posedge clk) mainDrop <= 1'b1;
    wait_out(0, 1'b0, 4, "main drop");
    @(posedge clk) mainDrop <= 1'b0;
    wait_out(0, 1'b1, 4, "main back");
    @(posedge clk) clkDrop <= 1'b1;
    wait_out(2, 1'b0, 4, "rtc stop");
    @(posedge clk) clkDrop <= 1'b0;
    wait_out(2, 1'b1, 4, "rtc run");
    // key-wake sequencing
    wr(PDR_ADDR_CTRL, 32'h0);
    rd(PDR_ADDR_CTRL, 32'h0, "mode key");
    wr(PDR_ADDR_CTRL, 32'h2);
    wait_out(0, 1'b0, 3, "cmd iso");
    wait_out(1, 1'b1, ISO + 4, "cmd off");
    rd(PDR_ADDR_STAT, 32'h0000_041E, "stat off");
    pulse(0);
    wait_out(1, 1'b0, 3, "key on");
    wait_out(0, 1'b1, WAKE + 4, "key iso rel");
    pulse(2);
    wait_out(0, 1'b0, 3, "ext iso");
    wait_out(1, 1'b1, ISO + 4, "ext off");
    pulse(1);
    wait_out(1, 1'b0, 3, "alarm on");
    wait_out(0, 1'b1, WAKE + 4, "alarm iso rel");
    pulse(2);
    wait_out(1, 1'b1, ISO + 6, "ext off 2");
    wr(PDR_ADDR_CTRL, 32'h1);
    wait_out(1, 1'b0, 3, "general clears off");
    wait_out(0, 1'b1, 3, "general follows main");
    report_and_stop;
  end
endmodule
`default_nettype wire
